// ### src/mcs_device.v
/*
 Device end of a four-wire clocked multidrop control bus: counts bus clock
 pulses, detects sync periods and the fault pulse, decodes the multiplex
 channel and gates data words by channel. Registers over APB.
 Assumes the bus clock and data pins are asynchronous and far slower than
 I_REF_CLK; the data pin is open drain (oe high pulls it low).
*/
`timescale 1ns/1ps
`include "mcs_defines.vh"
module mcs_device #(
	parameter SYNC_DET_CYC = `MCS_SYNC_DET_NS / `MCS_CLK_PERIOD_NS
) (
	input  wire        I_REF_CLK,    // 100 MHz reference clock
	input  wire        I_RESET_N,    // synchronous reset, low
	input  wire        I_PSEL,       // apb select
	input  wire        I_PENABLE,    // apb enable
	input  wire        I_PWRITE,     // apb direction
	input  wire [7:0]  I_PADDR,      // apb byte address
	input  wire [31:0] I_PWDATA,     // apb write data
	output reg  [31:0] O_PRDATA,     // apb read data
	output reg         O_PREADY,     // apb ready
	output reg         O_PSLVERR,    // apb error on unmapped address
	input  wire        I_BUS_CLK,    // bus clock pin
	input  wire        I_BUS_DATA,   // bus data pin level
	output reg         O_BUS_DATA_O, // bus data drive value, always low
	output reg         O_BUS_DATA_OE,// high pulls data line low
	output reg         O_BUS_FAULT   // link in fault state
);
	localparam integer DET_LAST_I = SYNC_DET_CYC - 1;
	localparam [15:0]  DET_LAST   = DET_LAST_I[15:0];

	wire [1:0] pins_s;
	wire       clk_s  = pins_s[0];
	wire       data_s = pins_s[1];

	mcs_sync2 #(.WIDTH(2)) u_sync (
		.i_clk   (I_REF_CLK),
		.i_rst_n (I_RESET_N),
		.i_async ({I_BUS_DATA, I_BUS_CLK}),
		.o_sync  (pins_s)
	);

	// registers
	reg [1:0]  ctrl_reg;
	reg [15:0] in_mux_reg;
	reg [15:0] out_mux_reg;
	reg [31:0] chan_lo_reg;
	reg [31:0] chan_hi_reg;
	reg [31:0] tx_mem [0:`MCS_MEM_WORDS-1];
	reg        fault_st_reg;
	// link state
	reg        clk_d_reg;
	reg        data_d_reg;
	reg [15:0] high_cnt_reg;
	reg        in_sync_reg;
	reg        frame_ok_reg;
	reg [8:0]  pulse_reg;
	reg        ovf_reg;
	reg        bfd_low_reg;
	reg        bfd_ok_reg;
	reg [3:0]  chan_sh_reg;
	reg [3:0]  chan_reg;
	reg        chan_vld_reg;
	reg [255:0] rx_buf_reg;
	reg [255:0] applied_reg;

	wire en      = ctrl_reg[`MCS_CTRL_EN_BIT];
	wire ms      = ctrl_reg[`MCS_CTRL_MS_BIT];
	wire rise    = clk_s & ~clk_d_reg;
	wire fall    = ~clk_s & clk_d_reg;
	wire d_fall  = ~data_s & data_d_reg;
	wire d_rise  = data_s & ~data_d_reg;
	wire any_mux = |in_mux_reg[15:1] | |out_mux_reg[15:1];

	wire [7:0] addr     = ms ? pulse_reg[8:1] : pulse_reg[7:0];
	wire       in_ph    = ms ? ~pulse_reg[0] : 1'b1;
	wire       out_ph   = ms ? pulse_reg[0] : 1'b1;
	wire [3:0] word     = addr[7:4];
	wire [63:0] chan_tab = {chan_hi_reg, chan_lo_reg};
	wire [3:0] word_ch  = chan_tab[{word, 2'b00} +: 4];
	wire       ch_match = chan_vld_reg & (word_ch == chan_reg);
	// word 0 is never multiplexed
	wire in_gate  = (word == 4'h0) | ~in_mux_reg[word] | ch_match;
	wire out_gate = (word == 4'h0) | ~out_mux_reg[word] | ch_match;
	wire chan_addr = (addr >= `MCS_CHAN_FIRST) & (addr <= `MCS_CHAN_LAST);
	wire tx_bit   = tx_mem[addr[7:5]][addr[4:0]];

	// link side: pulse counting, sync and fault pulse detection
	always @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			clk_d_reg     <= 1'b1;
			data_d_reg    <= 1'b1;
			high_cnt_reg  <= 16'h0000;
			in_sync_reg   <= 1'b0;
			frame_ok_reg  <= 1'b0;
			pulse_reg     <= 9'h000;
			ovf_reg       <= 1'b0;
			bfd_low_reg   <= 1'b0;
			bfd_ok_reg    <= 1'b0;
			chan_sh_reg   <= 4'h0;
			chan_reg      <= 4'h0;
			chan_vld_reg  <= 1'b0;
			rx_buf_reg    <= 256'h0;
			applied_reg   <= 256'h0;
			O_BUS_DATA_O  <= 1'b0;
			O_BUS_DATA_OE <= 1'b0;
			O_BUS_FAULT   <= 1'b0;
		end else begin
			clk_d_reg  <= clk_s;
			data_d_reg <= data_s;
			if (!clk_s || rise) begin
				high_cnt_reg <= 16'h0000;
			end else if (high_cnt_reg != DET_LAST) begin
				high_cnt_reg <= high_cnt_reg + 16'h0001;
			end
			if (rise) begin
				bfd_low_reg <= 1'b0;
				bfd_ok_reg  <= 1'b0;
			end else if (clk_s) begin
				// fault pulse: fall then rise while clock stays high
				if (d_fall) begin
					bfd_low_reg <= 1'b1;
				end
				if (d_rise && bfd_low_reg) begin
					bfd_ok_reg <= 1'b1;
				end
			end
			if (clk_s && !in_sync_reg && high_cnt_reg == DET_LAST) begin
				in_sync_reg   <= 1'b1;
				pulse_reg     <= 9'h000;
				ovf_reg       <= 1'b0;
				chan_vld_reg  <= 1'b0;
				O_BUS_DATA_OE <= 1'b0;
			end else if (fall) begin
				if (in_sync_reg) begin
					in_sync_reg <= 1'b0;
					if (bfd_ok_reg) begin
						applied_reg  <= rx_buf_reg;
						frame_ok_reg <= 1'b1;
						O_BUS_FAULT  <= 1'b0;
					end else begin
						applied_reg  <= 256'h0;
						frame_ok_reg <= 1'b0;
						O_BUS_FAULT  <= 1'b1;
					end
				end
				// drive low for a 1 during this address period
				O_BUS_DATA_OE <= en & (in_sync_reg ? bfd_ok_reg : frame_ok_reg) & ~ovf_reg
					& in_ph & in_gate & tx_bit
					& ~(any_mux & chan_addr);
			end else if (rise && !in_sync_reg) begin
				if (en && !ovf_reg && out_ph) begin
					if (out_gate) begin
						rx_buf_reg[addr] <= ~data_s;
					end
					if (chan_addr) begin
						chan_sh_reg[addr[1:0] - 2'h1] <= ~data_s;
					end
					if (addr == `MCS_CHAN_LAST) begin
						chan_reg     <= {~data_s, chan_sh_reg[2:0]};
						chan_vld_reg <= 1'b1;
					end
				end
				if (pulse_reg == {ms, 8'hFF}) begin
					ovf_reg <= 1'b1;
				end else begin
					pulse_reg <= pulse_reg + 9'h001;
				end
			end
		end
	end

	// apb slave: ready one cycle after setup, no wait states beyond that
	wire       setup  = I_PSEL & ~I_PENABLE;
	wire       access = I_PSEL & I_PENABLE & O_PREADY;
	wire       is_tx  = (I_PADDR >= `MCS_OFF_TX_BASE) & (I_PADDR <= `MCS_OFF_TX_LAST);
	wire       is_rx  = (I_PADDR >= `MCS_OFF_RX_BASE) & (I_PADDR <= `MCS_OFF_RX_LAST);
	wire [2:0] widx   = I_PADDR[4:2];
	wire       aligned = (I_PADDR[1:0] == 2'h0);
	reg        hit;
	reg [31:0] rd_next;

	always @* begin
		hit     = aligned;
		rd_next = 32'h0;
		if (I_PADDR == `MCS_OFF_CTRL) begin
			rd_next = {30'h0, ctrl_reg};
		end else if (I_PADDR == `MCS_OFF_STATUS) begin
			rd_next = {20'h0, chan_reg, 4'h0, chan_vld_reg, frame_ok_reg,
				in_sync_reg, fault_st_reg};
		end else if (I_PADDR == `MCS_OFF_IN_MUX) begin
			rd_next = {16'h0, in_mux_reg};
		end else if (I_PADDR == `MCS_OFF_OUT_MUX) begin
			rd_next = {16'h0, out_mux_reg};
		end else if (I_PADDR == `MCS_OFF_CHAN_LO) begin
			rd_next = chan_lo_reg;
		end else if (I_PADDR == `MCS_OFF_CHAN_HI) begin
			rd_next = chan_hi_reg;
		end else if (is_tx) begin
			rd_next = tx_mem[widx];
		end else if (is_rx) begin
			rd_next = applied_reg[{widx, 5'h00} +: 32];
		end else begin
			hit = 1'b0;
		end
	end

	wire fault_set = fall & in_sync_reg & ~bfd_ok_reg;
	integer i;

	always @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			O_PRDATA     <= 32'h0;
			O_PREADY     <= 1'b0;
			O_PSLVERR    <= 1'b0;
			ctrl_reg     <= `MCS_CTRL_RST;
			in_mux_reg   <= 16'h0;
			out_mux_reg  <= 16'h0;
			chan_lo_reg  <= 32'h0;
			chan_hi_reg  <= 32'h0;
			fault_st_reg <= 1'b0;
			for (i = 0; i < `MCS_MEM_WORDS; i = i + 1) begin
				tx_mem[i] <= 32'h0;
			end
		end else begin
			O_PREADY  <= setup;
			O_PSLVERR <= setup & ~hit;
			if (setup) begin
				O_PRDATA <= (I_PWRITE || !hit) ? 32'h0 : rd_next;
			end
			if (access && I_PWRITE && hit) begin
				if (I_PADDR == `MCS_OFF_CTRL) begin
					ctrl_reg <= I_PWDATA[1:0];
				end else if (I_PADDR == `MCS_OFF_IN_MUX) begin
					in_mux_reg <= {I_PWDATA[15:1], 1'b0};
				end else if (I_PADDR == `MCS_OFF_OUT_MUX) begin
					out_mux_reg <= {I_PWDATA[15:1], 1'b0};
				end else if (I_PADDR == `MCS_OFF_CHAN_LO) begin
					chan_lo_reg <= I_PWDATA;
				end else if (I_PADDR == `MCS_OFF_CHAN_HI) begin
					chan_hi_reg <= I_PWDATA;
				end else if (is_tx) begin
					tx_mem[widx] <= I_PWDATA;
				end
			end
			// sticky fault, write one to clear, new fault wins
			if (fault_set) begin
				fault_st_reg <= 1'b1;
			end else if (access && I_PWRITE && I_PADDR == `MCS_OFF_STATUS
					&& I_PWDATA[`MCS_ST_FAULT_BIT]) begin
				fault_st_reg <= 1'b0;
			end
		end
	end
endmodule // mcs_device

// ### pkg/mcs_defines.vh
/*
 Constants for the multiplexed-channel frame logic: register offsets,
 field positions, reset values and timing figures.
 Assumes a 100 MHz reference clock and 32-bit APB data.
*/
`ifndef MCS_DEFINES_VH
`define MCS_DEFINES_VH

// timing
`define MCS_CLK_PERIOD_NS   10
`define MCS_SYNC_DET_NS     70000

// bus geometry
`define MCS_ADDR_W          8
`define MCS_CNT_W           9
`define MCS_CHAN_W          4
`define MCS_NUM_WORDS       16
`define MCS_MEM_WORDS       8

// register byte offsets
`define MCS_OFF_CTRL        8'h00
`define MCS_OFF_STATUS      8'h04
`define MCS_OFF_IN_MUX      8'h08
`define MCS_OFF_OUT_MUX     8'h0C
`define MCS_OFF_CHAN_LO     8'h10
`define MCS_OFF_CHAN_HI     8'h14
`define MCS_OFF_TX_BASE     8'h20
`define MCS_OFF_RX_BASE     8'h40
`define MCS_OFF_TX_LAST     8'h3C
`define MCS_OFF_RX_LAST     8'h5C

// control fields
`define MCS_CTRL_EN_BIT     0
`define MCS_CTRL_MS_BIT     1
`define MCS_CTRL_RST        2'h0

// status fields
`define MCS_ST_FAULT_BIT    0
`define MCS_ST_SYNC_BIT     1
`define MCS_ST_LINK_BIT     2
`define MCS_ST_CHVLD_BIT    3
`define MCS_ST_CHAN_LSB     8

// channel indication position in word 0
`define MCS_CHAN_FIRST      8'h01
`define MCS_CHAN_LAST       8'h04

`endif

// ### src/mcs_sync2.v
/*
 Two-flop synchroniser for a group of asynchronous levels.
 Assumes inputs are slow levels relative to the clock.
*/
`timescale 1ns/1ps
module mcs_sync2 #(
	parameter WIDTH = 1
) (
	input  wire             i_clk,   // sampling clock
	input  wire             i_rst_n, // synchronous reset, low
	input  wire [WIDTH-1:0] i_async, // asynchronous levels
	output reg  [WIDTH-1:0] o_sync   // synchronised levels
);
	reg [WIDTH-1:0] meta_reg;

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_reg <= {WIDTH{1'b1}};
			o_sync   <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule // mcs_sync2

// ### verif/mcs_device_checker.sv
/* assertion checker for mcs_device, bound below.
 assumes the bench sets SYNC_DET_CYC on the design. */
`timescale 1ns/1ps
module mcs_device_checker #(
	parameter SYNC_DET_CYC = 50
) (
	input wire        I_REF_CLK,     // clock
	input wire        I_RESET_N,     // reset, low
	input wire        I_PSEL,        // select
	input wire        I_PENABLE,     // enable
	input wire        I_PWRITE,      // direction
	input wire [31:0] O_PRDATA,      // read data
	input wire        O_PREADY,      // ready
	input wire        O_PSLVERR,     // error
	input wire        I_BUS_CLK,     // bus clock
	input wire        O_BUS_DATA_O,  // drive value
	input wire        O_BUS_DATA_OE, // drive enable
	input wire        O_BUS_FAULT    // fault
);
	reg [15:0] hi_cnt;
	// cycles the bus clock pin has stayed high
	always @(posedge I_REF_CLK) begin
		if (!I_RESET_N || !I_BUS_CLK)
			hi_cnt <= 16'h0;
		else if (hi_cnt != 16'hFFFF)
			hi_cnt <= hi_cnt + 16'h1;
	end
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESET_N);
	sequence s_setup;
		I_PSEL && !I_PENABLE;
	endsequence
	sequence s_clk_rise;
		!I_BUS_CLK ##1 I_BUS_CLK;
	endsequence
	AST_RESET_QUIET: assert property (disable iff (1'b0)
		!I_RESET_N |=> !O_BUS_DATA_OE && !O_BUS_FAULT && !O_PREADY)
		else $error("output active after reset");
	AST_DRIVE_LOW: assert property (O_BUS_DATA_O == 1'b0)
		else $error("data drive value not low");
	AST_SYNC_RELEASE: assert property (hi_cnt > SYNC_DET_CYC + 8 |-> !O_BUS_DATA_OE)
		else $error("data driven in sync");
	AST_OE_STANDS: assert property (s_clk_rise |=> $stable(O_BUS_DATA_OE)[*3])
		else $error("drive changed mid period");
	AST_FAULT_AT_FRAME: assert property ($changed(O_BUS_FAULT) |-> $past(hi_cnt, 8) > SYNC_DET_CYC)
		else $error("fault moved outside frame start");
	AST_SETUP_READY: assert property (s_setup |=> O_PREADY)
		else $error("no ready after setup");
	AST_READY_ONE: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	AST_ERR_WITH_READY: assert property (O_PSLVERR |-> O_PREADY && I_PSEL && I_PENABLE)
		else $error("error without ready");
	AST_ERR_READ_ZERO: assert property (O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
		else $error("error read not zero");
endmodule // mcs_device_checker

bind mcs_device mcs_device_checker #(.SYNC_DET_CYC(SYNC_DET_CYC)) u_chk (
	.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_BUS_CLK(I_BUS_CLK),
	.O_BUS_DATA_O(O_BUS_DATA_O), .O_BUS_DATA_OE(O_BUS_DATA_OE), .O_BUS_FAULT(O_BUS_FAULT)
);

// ### verif/mcs_src_model.sv
/* bus clock source model: 48-address frames, one or two pulses each, channel on addresses 1..4,
 scaled sync with optional fault pulse. data line pulled up, wire-and. */
`timescale 1ns/1ps
module mcs_src_model (
	output reg         o_bus_clk, // bus clock
	output wire        o_line,    // data line level
	input  wire        i_dev_oe,  // device pulls low
	input  wire        i_ms,      // two pulses per address
	input  wire [47:0] i_bits,    // source bits by address
	output reg  [47:0] o_seen     // line bits per address
);
	reg src_low = 1'b0;
	reg fault_low = 1'b0;
	assign o_line = !(i_dev_oe || src_low || fault_low);
	initial begin
		o_bus_clk = 1'b1;
		o_seen = 48'h0;
	end
	task run_frame(input [3:0] ch, input bfd);
		integer p;
		integer a;
		begin
			// pin edges kept 2 ns off the reference clock edges
			#2;
			for (p = 0; p < (i_ms ? 96 : 48); p = p + 1) begin
				a = i_ms ? p / 2 : p;
				o_bus_clk = 1'b0;
				// two-pulse mode: even pulse is the device's report
				if (i_ms && p % 2 == 0)
					src_low = 1'b0;
				else
					src_low = (a >= 1 && a <= 4) ? ch[a-1] : i_bits[a];
				#40 o_bus_clk = 1'b1;
				#35;
				if (!i_ms || p % 2 == 0)
					o_seen[a] = !o_line;
				#5;
			end
			src_low = 1'b0;
			// clock held high; 16.5 periods in all with the next lead-in
			#680 fault_low = bfd;
			#160 fault_low = 1'b0;
			#438;
		end
	endtask
endmodule // mcs_src_model

// ### verif/mcs_device_tb.sv
/* bench for mcs_device: apb tasks and frames from the source model.
 sync detection scaled to 50 cycles; bus clock period 80 ns. */
`timescale 1ns/1ps
`include "mcs_defines.vh"
module mcs_device_tb;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg  [31:0] rdata;
	reg         rerr;
	reg  [47:0] bits = 48'h0100_0010_0000;
	reg         ms = 1'b0;
	wire [31:0] prdata;
	wire        pready, pslverr, bus_clk, line, oe, fault;
	wire [47:0] seen;
	integer     fail_count = 0;
	integer     compares = 0;
	always #5 clk = !clk;
	mcs_device #(.SYNC_DET_CYC(50)) DUT (
		.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_BUS_CLK(bus_clk), .I_BUS_DATA(line),
		.O_BUS_DATA_O(), .O_BUS_DATA_OE(oe), .O_BUS_FAULT(fault)
	);
	mcs_src_model u_src (
		.o_bus_clk(bus_clk), .o_line(line), .i_dev_oe(oe), .i_ms(ms), .i_bits(bits),
		.o_seen(seen)
	);
	task check(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task summarize;
		begin
			$display("compares=%0d fail_count=%0d", compares, fail_count);
			if (fail_count == 0 && compares > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task apb(input wr_en, input [7:0] addr, input [31:0] wd);
		integer n;
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= wr_en;
			paddr <= addr;
			pwdata <= wd;
			@(posedge clk);
			penable <= 1'b1;
			n = 0;
			@(posedge clk);
			while (pready !== 1'b1 && n < 20) begin
				n = n + 1;
				@(posedge clk);
			end
			if (pready !== 1'b1) begin
				fail_count = fail_count + 1;
				summarize;
			end else begin
				rdata = prdata;
				rerr = pslverr;
				psel <= 1'b0;
				penable <= 1'b0;
			end
		end
	endtask
	task rd(input [7:0] addr, input [31:0] mask, input [31:0] exp);
		begin
			apb(1'b0, addr, 32'h0);
			check(rdata & mask, exp);
		end
	endtask
	task frame(input [3:0] ch, input bfd, input [31:0] exp);
		begin
			u_src.run_frame(ch, bfd);
			check(seen[31:0], exp);
			$display("frame on channel %0d done", ch);
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(`MCS_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
		apb(1'b0, 8'hF0, 32'h0);
		check({31'h0, rerr}, 32'h1);
		apb(1'b1, `MCS_OFF_CTRL, 32'h1);
		apb(1'b1, `MCS_OFF_IN_MUX, 32'h3);
		rd(`MCS_OFF_IN_MUX, 32'hFFFF, 32'h2);
		apb(1'b1, `MCS_OFF_OUT_MUX, 32'h2);
		apb(1'b1, `MCS_OFF_CHAN_LO, 32'h20);
		// address 1 queued too: must stay undriven
		apb(1'b1, `MCS_OFF_TX_BASE, 32'h0001_0022);
		$display("register setup done");
		frame(4'h2, 1'b1, 32'h0010_0004);
		frame(4'h2, 1'b1, 32'h0011_0024);
		rd(`MCS_OFF_RX_BASE + 8'h04, 32'hFFFF_FFFF, 32'h100);
		rd(`MCS_OFF_RX_BASE, 32'h0010_0000, 32'h0010_0000);
		rd(`MCS_OFF_STATUS, 32'h0000_0F06, 32'h0000_0206);
		// mux bit 20 now clear: the unmatched frame must not take it
		bits <= 48'h0100_0000_0000;
		frame(4'h5, 1'b1, 32'h0000_002A);
		frame(4'h2, 1'b0, 32'h0001_0024);
		rd(`MCS_OFF_RX_BASE, 32'h0010_0000, 32'h0010_0000);
		check({31'h0, fault}, 32'h0);
		u_src.run_frame(4'h2, 1'b1);
		check({31'h0, fault}, 32'h1);
		rd(`MCS_OFF_RX_BASE + 8'h04, 32'hFFFF_FFFF, 32'h0);
		rd(`MCS_OFF_STATUS, 32'h1, 32'h1);
		apb(1'b1, `MCS_OFF_STATUS, 32'h1);
		rd(`MCS_OFF_STATUS, 32'h1, 32'h0);
		u_src.run_frame(4'h2, 1'b1);
		check({31'h0, fault}, 32'h0);
		$display("fault recovery done");
		apb(1'b1, `MCS_OFF_CTRL, 32'h3);
		ms <= 1'b1;
		frame(4'h2, 1'b1, 32'h0001_0020);
		summarize;
	end
endmodule // mcs_device_tb
